//--- core/cmc_pkg.sv
// constants and decode helpers for the clock multiplier control block
// assumes a byte-wide special-function register port in the system clock domain
//
// Behaviour
// R1 - enable bit seven switches multiplier on/off
// R2 - init bit reads 0; write 1 starts lock
// R3 - read-only ready flag shows lock achieved
// R4 - scale field bits 4:2 picks output factor
// R5 - odd scale settings give asymmetric duty cycle
// R6 - select field bits 1:0 picks base clock
// R7 - times-two base ignores the scale field
// R8 - software keeps system clock within 50 MHz
// R9 - crystal mode claims pins P0.2 and P0.3
// R10 - capacitor, RC, CMOS modes claim P0.3 only
// R11 - software makes crossbar skip oscillator pins
// R12 - software sets oscillator pins analog input
// R13 - CMOS mode pin is digital input
// R14 - bring-up: zero, configure, enable, wait, init, poll
// R15 - external source stable before init is set
// R16 - writing zero returns multiplier disabled and unlocked
package cmc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0] CMC_CTRL_ADDR = 8'h97;
    localparam logic [7:0] CMC_CTRL_RESET = 8'h00;

    localparam int CMC_EN_BIT = 7;
    localparam int CMC_INIT_BIT = 6;
    localparam int CMC_RDY_BIT = 5;
    localparam int CMC_SCALE_MSB = 4;
    localparam int CMC_SCALE_LSB = 2;
    localparam int CMC_SEL_MSB = 1;
    localparam int CMC_SEL_LSB = 0;

    // select field: bit 0 picks external source, bit 1 picks times four
    localparam int CMC_SEL_EXT_BIT = 0;
    localparam int CMC_SEL_X4_BIT = 1;

    // scale numerator is always two; denominator two means factor one
    localparam logic [2:0] CMC_DENOM_UNITY = 3'h2;

    ////////////////////////////////////////////////////////////////////////////
    // external oscillator mode codes, as held by the oscillator control register
    localparam logic [2:0] CMC_XMODE_OFF = 3'h0;
    localparam logic [2:0] CMC_XMODE_CMOS = 3'h2;
    localparam logic [2:0] CMC_XMODE_CMOS_DIV2 = 3'h3;
    localparam logic [2:0] CMC_XMODE_RC = 3'h4;
    localparam logic [2:0] CMC_XMODE_CAP = 3'h5;
    localparam logic [2:0] CMC_XMODE_XTAL = 3'h6;
    localparam logic [2:0] CMC_XMODE_XTAL_DIV2 = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CMC_CLK_PERIOD_PS = 25000;
    localparam int CMC_SETTLE_TIME_NS = 5000;
    localparam int CMC_SETTLE_CYCLES =
        (CMC_SETTLE_TIME_NS * 1000 + CMC_CLK_PERIOD_PS - 1) / CMC_CLK_PERIOD_PS;
    localparam int CMC_LOCK_TIME_NS = 20000;
    localparam int CMC_LOCK_CYCLES =
        (CMC_LOCK_TIME_NS * 1000 + CMC_CLK_PERIOD_PS - 1) / CMC_CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        CMC_OFF,
        CMC_ENABLED,
        CMC_LOCKING,
        CMC_LOCKED
    } cmc_state_type;

    // effective divider; used by the scaler path and the status outputs
    function automatic logic [2:0] cmc_denom(input logic [2:0] scale, input logic x4);
        if (!x4 || scale < 3'h3) begin
            return CMC_DENOM_UNITY;
        end
        return scale;
    endfunction

    function automatic logic cmc_mode_one_pin(input logic [2:0] mode);
        return (mode == CMC_XMODE_CMOS) || (mode == CMC_XMODE_CMOS_DIV2) ||
               (mode == CMC_XMODE_RC) || (mode == CMC_XMODE_CAP);
    endfunction

endpackage

//--- core/cmc_scaler.sv
// output scaler: passes two of every N base ticks, N from 2 to 7
// assumes base ticks are single-cycle strobes in the system clock domain
module cmc_scaler
    import cmc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // control
    input wire logic run_i,
    input wire logic [2:0] denom_i,
    input wire logic base_tick_i,
    // output
    output logic tick_o
);

    logic [3:0] acc_q;
    logic [3:0] acc_d;
    logic tick_q;
    logic tick_d;
    wire logic [3:0] sum = acc_q + 4'h2;
    wire logic hit = sum >= {1'b0, denom_i};

    // pulses bunch up for odd N, so the output is not half high half low
    always_comb begin
        acc_d = acc_q;
        tick_d = 1'b0;
        if (!run_i) begin
            acc_d = 4'h0;
        end else if (base_tick_i) begin
            acc_d = hit ? sum - {1'b0, denom_i} : sum; // R4 R5
            tick_d = hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            acc_q <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;

endmodule

//--- core/cmc_top.sv
// clock multiplier control register, lock sequencing, output scaling
// and external oscillator pin claims
// assumes a single-cycle byte register port and a base tick from the analog multiplier
module cmc_top
    import cmc_pkg::*;
#(
    parameter int LOCK_CYCLES = CMC_LOCK_CYCLES,
    parameter int SETTLE_CYCLES = CMC_SETTLE_CYCLES
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // oscillator side
    input wire logic [2:0] ext_osc_mode_i,
    input wire logic base_tick_i,
    // multiplier controls and status
    output logic mult_enable_o,
    output logic mult_init_pulse_o,
    output logic mult_locked_o,
    output logic mult_src_external_o,
    output logic mult_base_x4_o,
    output logic [2:0] mult_denom_o,
    output logic mult_clk_tick_o,
    output logic mult_settled_o,
    // port pin claims
    output logic osc_pin_a_claim_o,
    output logic osc_pin_b_claim_o,
    output logic osc_pin_b_digital_o
);

    ////////////////////////////////////////////////////////////////////////////
    // parameter checks

    // counters are sixteen bits wide; refuse counts they cannot hold
    if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65535) begin : g_lock_range
        $error("lock count out of range");
    end
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_settle_range
        $error("settle count out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // register decode

    cmc_state_type state_q;
    cmc_state_type state_d;
    logic enable_q;
    logic [2:0] scale_q;
    logic [1:0] sel_q;
    logic [15:0] lock_cnt_q;
    logic [15:0] lock_cnt_d;
    logic [15:0] settle_cnt_q;
    logic settled_q;
    logic init_pulse_q;
    logic [7:0] rdata_q;

    wire logic hit = sfr_addr_i == CMC_CTRL_ADDR;
    wire logic wr = hit && sfr_wr_i;
    wire logic rd = hit && sfr_rd_i;
    wire logic wr_en = sfr_wdata_i[CMC_EN_BIT];
    wire logic wr_init = sfr_wdata_i[CMC_INIT_BIT];
    wire logic [2:0] wr_scale = sfr_wdata_i[CMC_SCALE_MSB:CMC_SCALE_LSB];
    wire logic [1:0] wr_sel = sfr_wdata_i[CMC_SEL_MSB:CMC_SEL_LSB];

    // init only counts once the multiplier was already enabled before this write
    wire logic start_lock = wr && wr_en && wr_init && enable_q; // R2 R14
    wire logic locked = state_q == CMC_LOCKED;
    wire logic x4 = sel_q[CMC_SEL_X4_BIT];
    wire logic [2:0] denom = cmc_denom(scale_q, x4); // R7

    wire logic [15:0] lock_last = 16'(LOCK_CYCLES - 1);
    wire logic [15:0] settle_last = 16'(SETTLE_CYCLES - 1);

    // init bit is never stored, so it always reads back as zero
    wire logic [7:0] rd_value = {enable_q, 1'b0, locked, scale_q, sel_q}; // R2 R3

    ////////////////////////////////////////////////////////////////////////////
    // lock sequencer

    always_comb begin
        state_d = state_q;
        lock_cnt_d = lock_cnt_q;
        unique case (state_q)
            CMC_OFF: begin
                if (wr && wr_en) begin
                    state_d = CMC_ENABLED; // R1
                end
            end
            CMC_ENABLED: begin
                if (start_lock) begin
                    state_d = CMC_LOCKING;
                    lock_cnt_d = 16'h0000;
                end
            end
            CMC_LOCKING: begin
                if (lock_cnt_q == lock_last) begin
                    state_d = CMC_LOCKED; // R3
                end else begin
                    lock_cnt_d = lock_cnt_q + 16'h0001;
                end
            end
            CMC_LOCKED: begin
                // a new init request relocks from scratch
                if (start_lock) begin
                    state_d = CMC_LOCKING;
                    lock_cnt_d = 16'h0000;
                end
            end
        endcase
        // re-init inside LOCKING also restarts the count
        if (state_q == CMC_LOCKING && start_lock) begin
            lock_cnt_d = 16'h0000;
            state_d = CMC_LOCKING;
        end
        // clearing the enable drops lock at once, whatever the state
        if (wr && !wr_en) begin
            state_d = CMC_OFF; // R1 R16
            lock_cnt_d = 16'h0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= CMC_OFF;
            lock_cnt_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            lock_cnt_q <= lock_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control fields

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            enable_q <= CMC_CTRL_RESET[CMC_EN_BIT];
            scale_q <= CMC_CTRL_RESET[CMC_SCALE_MSB:CMC_SCALE_LSB];
            sel_q <= CMC_CTRL_RESET[CMC_SEL_MSB:CMC_SEL_LSB];
            init_pulse_q <= 1'b0;
        end else begin
            init_pulse_q <= start_lock;
            if (wr) begin
                enable_q <= wr_en; // R1 R16
                scale_q <= wr_scale; // R4
                sel_q <= wr_sel; // R6
            end
        end
    end

    // enable settle timer; status only, the init is not held back by it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            settle_cnt_q <= 16'h0000;
            settled_q <= 1'b0;
        end else if (!enable_q || (wr && !wr_en)) begin
            settle_cnt_q <= 16'h0000;
            settled_q <= 1'b0;
        end else if (!settled_q) begin
            settled_q <= settle_cnt_q == settle_last;
            settle_cnt_q <= settle_cnt_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port; unmapped addresses and idle cycles read zero

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd ? rd_value : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output scaling; the scaler only runs once locked

    cmc_scaler u_scaler (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(locked),
        .denom_i(denom),
        .base_tick_i(base_tick_i),
        .tick_o(mult_clk_tick_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // oscillator pin claims; crossbar skip and pin modes stay with software

    logic pin_a_q;
    logic pin_b_q;
    logic pin_b_dig_q;
    wire logic mode_xtal = (ext_osc_mode_i == CMC_XMODE_XTAL) ||
                           (ext_osc_mode_i == CMC_XMODE_XTAL_DIV2);
    wire logic mode_one = cmc_mode_one_pin(ext_osc_mode_i);
    wire logic mode_cmos = (ext_osc_mode_i == CMC_XMODE_CMOS) ||
                           (ext_osc_mode_i == CMC_XMODE_CMOS_DIV2);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_a_q <= 1'b0;
            pin_b_q <= 1'b0;
            pin_b_dig_q <= 1'b0;
        end else begin
            pin_a_q <= mode_xtal; // R9
            pin_b_q <= mode_xtal || mode_one; // R9 R10
            pin_b_dig_q <= mode_cmos; // R13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign sfr_rdata_o = rdata_q;
    assign mult_enable_o = enable_q;
    assign mult_init_pulse_o = init_pulse_q;
    assign mult_locked_o = locked;
    assign mult_src_external_o = sel_q[CMC_SEL_EXT_BIT];
    assign mult_base_x4_o = x4;
    assign mult_denom_o = denom;
    assign mult_settled_o = settled_q;
    assign osc_pin_a_claim_o = pin_a_q;
    assign osc_pin_b_claim_o = pin_b_q;
    assign osc_pin_b_digital_o = pin_b_dig_q;

endmodule

//--- sim/cmc_top_asserts.sv
// concurrent checks on the clock multiplier control ports
// assumes one clock domain; bound into cmc_top below
module cmc_top_asserts
    import cmc_pkg::*;
#(
    parameter int LOCK_CYCLES = CMC_LOCK_CYCLES
)(
    // clock, reset, register port
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    // oscillator side
    input wire logic [2:0] ext_osc_mode_i,
    input wire logic base_tick_i,
    // multiplier outputs
    input wire logic mult_enable_o,
    input wire logic mult_init_pulse_o,
    input wire logic mult_locked_o,
    input wire logic mult_src_external_o,
    input wire logic mult_base_x4_o,
    input wire logic [2:0] mult_denom_o,
    input wire logic mult_clk_tick_o,
    input wire logic osc_pin_a_claim_o,
    input wire logic osc_pin_b_claim_o,
    input wire logic osc_pin_b_digital_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire hit = sfr_wr_i && (sfr_addr_i == CMC_CTRL_ADDR);
    // init only counts once the multiplier is already on
    sequence init_wr_s;
        hit && sfr_wdata_i[7:6] == 2'h3 && mult_enable_o;
    endsequence
    ////////////////////////////////////////////////////////
    en_follow_a: assert property (hit |=> mult_enable_o == $past(sfr_wdata_i[7]))
        else $error("enable bit not taken");
    sel_follow_a: assert property (hit |=>
        {mult_base_x4_o, mult_src_external_o} == $past(sfr_wdata_i[1:0]))
        else $error("select field not taken");
    init_pulse_a: assert property (init_wr_s |=> mult_init_pulse_o)
        else $error("init write gave no pulse");
    init_guard_a: assert property (mult_init_pulse_o |->
        $past(hit && sfr_wdata_i[7:6] == 2'h3 && mult_enable_o))
        else $error("init pulse without enabled init write");
    lock_time_a: assert property ($rose(mult_locked_o) |->
        $past(mult_init_pulse_o, LOCK_CYCLES))
        else $error("ready rose at wrong time");
    zero_off_a: assert property (hit && sfr_wdata_i == 8'h00 |=>
        !mult_enable_o && !mult_locked_o)
        else $error("zero write did not switch off");
    denom_set_a: assert property (hit |=> mult_denom_o ==
        (($past(sfr_wdata_i[1]) && $past(sfr_wdata_i[4:2]) > 3'h2) ?
        $past(sfr_wdata_i[4:2]) : 3'h2))
        else $error("divider wrong after write");
    tick_src_a: assert property (mult_clk_tick_o |->
        $past(base_tick_i) && $past(mult_locked_o))
        else $error("output tick without locked base tick");
    pin_a_a: assert property (1'h1 |=> osc_pin_a_claim_o == ($past(ext_osc_mode_i) > 3'h5))
        else $error("first pin claim wrong");
    pin_b_a: assert property (1'h1 |=>
        osc_pin_b_claim_o == ($past(ext_osc_mode_i) > 3'h1))
        else $error("second pin claim wrong");
    pin_dig_a: assert property (1'h1 |=>
        osc_pin_b_digital_o == ($past(ext_osc_mode_i[2:1]) == 2'h1))
        else $error("digital pin flag wrong");
endmodule

bind cmc_top cmc_top_asserts #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .ext_osc_mode_i(ext_osc_mode_i), .base_tick_i(base_tick_i),
    .mult_enable_o(mult_enable_o), .mult_init_pulse_o(mult_init_pulse_o),
    .mult_locked_o(mult_locked_o), .mult_src_external_o(mult_src_external_o),
    .mult_base_x4_o(mult_base_x4_o), .mult_denom_o(mult_denom_o),
    .mult_clk_tick_o(mult_clk_tick_o), .osc_pin_a_claim_o(osc_pin_a_claim_o),
    .osc_pin_b_claim_o(osc_pin_b_claim_o), .osc_pin_b_digital_o(osc_pin_b_digital_o));

//--- sim/cmc_osc_model.sv
// oscillator source model: a burst of base ticks at a fixed spacing
// assumes the bench starts it only after the multiplier reports lock
module cmc_osc_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // burst control
    input wire logic start_i,
    input wire logic [1:0] gap_i,
    input wire logic [9:0] count_i,
    // base ticks
    output logic tick_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int left_q;
    int wait_q;
    // spacing stays fixed within a burst, so the source is steady
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            left_q <= 0;
            wait_q <= 0;
            tick_o <= 1'b0;
        end else if (start_i) begin
            left_q <= int'(count_i);
            wait_q <= int'(gap_i);
            tick_o <= 1'b0;
        end else begin
            tick_o <= left_q > 0 && wait_q == 0;
            left_q <= (left_q > 0 && wait_q == 0) ? left_q - 1 : left_q;
            wait_q <= (wait_q == 0) ? int'(gap_i) : wait_q - 1;
        end
    end
    assign busy_o = (left_q != 0) || tick_o;
endmodule

//--- sim/tb_top.sv
// self-checking bench for the clock multiplier control block
// assumes shortened lock and settle counts; ticks come from the oscillator model
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cmc_pkg::*;
    localparam int LOCK = 4;
    localparam int SETTLE = 3;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] sfr_addr_i = 8'h00;
    logic sfr_wr_i = 1'b0;
    logic sfr_rd_i = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic [2:0] ext_osc_mode_i = 3'h0;
    logic start = 1'b0;
    logic [1:0] gap = 2'h0;
    logic base_tick, osc_busy, en, ini, lck, ext, x4, ctk, stl, pa, pb, pd;
    logic [7:0] sfr_rdata_o;
    logic [7:0] d;
    logic [2:0] den;
    int n_errors = 0;
    int n_compared = 0;
    int n_ticks = 0;
    int m_n;
    cmc_top #(.LOCK_CYCLES(LOCK), .SETTLE_CYCLES(SETTLE)) uut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .ext_osc_mode_i(ext_osc_mode_i), .base_tick_i(base_tick), .mult_enable_o(en),
        .mult_init_pulse_o(ini), .mult_locked_o(lck), .mult_src_external_o(ext),
        .mult_base_x4_o(x4), .mult_denom_o(den), .mult_clk_tick_o(ctk), .mult_settled_o(stl),
        .osc_pin_a_claim_o(pa), .osc_pin_b_claim_o(pb), .osc_pin_b_digital_o(pd));
    cmc_osc_model osc (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(start), .gap_i(gap),
        .count_i(10'h1A4), .tick_o(base_tick), .busy_o(osc_busy));
    initial forever #12.5 clk_i = ~clk_i;
    // count on the falling edge so the tick is settled, clear of the launching edge
    always @(negedge clk_i) if (ctk === 1'b1) n_ticks++;
    ////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= v;
        sfr_wr_i <= 1'b1;
        @(posedge clk_i);
        sfr_wr_i <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_i);
        sfr_addr_i <= a;
        sfr_rd_i <= 1'b1;
        @(posedge clk_i);
        sfr_rd_i <= 1'b0;
        @(negedge clk_i);
        d = sfr_rdata_o;
    endtask
    task automatic expire(input string what);
        n_errors++;
        $display("Error %s expected done seen busy", what);
        conclude();
    endtask
    // zero, configure, enable, settle, init, poll ready
    task automatic bring_up(input logic [7:0] cfg);
        wr_reg(CMC_CTRL_ADDR, 8'h00);
        wr_reg(CMC_CTRL_ADDR, cfg);
        wr_reg(CMC_CTRL_ADDR, cfg | 8'h80);
        repeat (SETTLE + 2) @(negedge clk_i);
        chk("settled", stl, 1'h1);
        wr_reg(CMC_CTRL_ADDR, cfg | 8'hC0);
        for (int i = 0; i < 40 && lck !== 1'b1; i++) @(negedge clk_i);
        if (lck !== 1'b1) expire("lock");
        rd_reg(CMC_CTRL_ADDR);
        chk("ctrl_locked", d, 8'hA0 | (cfg & 8'h1F));
    endtask
    task automatic conclude;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h66050E9C));
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd_reg(CMC_CTRL_ADDR);
        chk("ctrl_reset", d, 8'h00);
        wr_reg(CMC_CTRL_ADDR, 8'hFF);
        // give a wrongly accepted init time to reach lock before looking
        repeat (LOCK + 2) @(posedge clk_i);
        rd_reg(CMC_CTRL_ADDR);
        chk("init_refused", d, 8'h9F);
        chk("no_lock", lck, 1'h0);
        rd_reg(8'h96);
        chk("unmapped", d, 8'h00);
        $display("test register done");
        for (int m = 0; m < 8; m++) begin
            @(posedge clk_i);
            ext_osc_mode_i <= 3'(m);
            repeat (2) @(negedge clk_i);
            chk("pins", {pa, pb, pd}, {m > 5, m > 1, m / 2 == 1});
            chk("pin_analog", pb & ~pd, m > 3);
        end
        $display("test pins done");
        // every scale with every select; 420 base ticks divide evenly by 2..7
        for (int s = 0; s < 32; s++) begin
            bring_up(8'(s));
            m_n = (s[1] && s / 4 > 2) ? s / 4 : 2;
            @(posedge clk_i);
            n_ticks = 0;
            gap <= 2'($urandom_range(3));
            start <= 1'b1;
            @(posedge clk_i);
            start <= 1'b0;
            @(negedge clk_i);
            for (int i = 0; i < 2000 && osc_busy !== 1'b0; i++) @(negedge clk_i);
            if (osc_busy !== 1'b0) expire("burst");
            repeat (3) @(negedge clk_i);
            chk("ticks", 16'(n_ticks), 16'(840 / m_n));
            chk("no_speedup", n_ticks <= 420, 1'b1);
        end
        $display("test scaling done");
        wr_reg(CMC_CTRL_ADDR, 8'h00);
        rd_reg(CMC_CTRL_ADDR);
        chk("zero_off", d, 8'h00);
        chk("locked", lck, 1'h0);
        $display("test zero done");
        conclude();
    end
endmodule
